// ===== hdl/shared_bus_mux_intercon.sv
// shared-bus interconnect: round-robin arbiter, owner muxes, address comparator, return paths
// assumes masters and slaves are synchronous logic on ref_clk_i; rst_i comes from the
// system controller already aligned to the clock, so no synchroniser is placed on it
module shared_bus_mux_intercon
    import shared_bus_mux_pkg::*;
#(
    // port counts are parameters, four of each by default
    parameter int NM = NUM_MASTERS,
    parameter int NS = NUM_SLAVES,
    parameter int AW = ADR_WIDTH,
    parameter int DW = DAT_WIDTH,
    parameter int SW = SEL_WIDTH,
    parameter logic [NS-1:0][AW-1:0] REGION_BASE = REGION_BASE_DEF,
    parameter logic [NS-1:0][AW-1:0] REGION_MASK = REGION_MASK_DEF
) (
    // separate in and out ports, none bidirectional
    input wire logic ref_clk_i, // interconnect clock
    input wire logic rst_i, // async reset, active high
    // master side
    input wire logic [NM-1:0] m_cyc_i, // bus requests
    input wire logic [NM-1:0] m_stb_i, // master strobes
    input wire logic [NM-1:0] m_we_i, // master write enables
    input wire logic [NM-1:0][AW-1:0] m_adr_i, // master addresses
    input wire logic [NM-1:0][DW-1:0] m_dat_i, // master write data
    input wire logic [NM-1:0][SW-1:0] m_sel_i, // master byte selects
    output logic [NM-1:0] m_ack_o, // gated acknowledge
    output logic [NM-1:0] m_rty_o, // gated retry
    output logic [NM-1:0] m_err_o, // gated error
    output logic [DW-1:0] m_dat_o, // read data to owner
    output logic [NM-1:0] grant_line_master_o, // one-hot grant lines
    output logic [((NM > 1) ? $clog2(NM) : 1)-1:0] grant_index_o, // owner index
    output logic grant_valid_o, // some master owns the bus
    // slave side
    output logic [AW-1:0] s_adr_o, // shared address
    output logic [DW-1:0] s_dat_o, // shared write data
    output logic [SW-1:0] s_sel_o, // shared byte selects
    output logic s_we_o, // shared write enable
    output logic s_cyc_o, // shared cycle
    output logic [NS-1:0] s_stb_o, // per-slave strobe
    input wire logic [NS-1:0] s_ack_i, // slave acknowledges
    input wire logic [NS-1:0] s_rty_i, // slave retries
    input wire logic [NS-1:0] s_err_i, // slave errors
    input wire logic [NS-1:0][DW-1:0] s_dat_i // slave read data
);

    localparam int IW = (NM > 1) ? $clog2(NM) : 1;
    localparam int SIW = (NS > 1) ? $clog2(NS) : 1;

    typedef struct packed {
        arb_state_t state;
        logic [NM-1:0] grant;
        logic [IW-1:0] last;
    } state_t;

    localparam state_t STATE_RST = '{state: ARB_IDLE, grant: '0, last: '0};

    state_t st_q;
    state_t st_d;

    // next requester after the previous owner; previous owner comes last
    function automatic logic [NM-1:0] rr_pick(input logic [NM-1:0] req, input logic [IW-1:0] last);
        logic [NM-1:0] res;
        int idx;
        res = '0;
        idx = 0;
        for (int k = NM; k >= 1; k--) begin
            idx = (int'(last) + k) % NM;
            if (req[idx]) begin
                res = '0;
                res[idx] = 1'b1;
            end
        end
        return res;
    endfunction

    // one-hot to index; zero vector gives zero
    function automatic logic [IW-1:0] m_index(input logic [NM-1:0] oh);
        logic [IW-1:0] res;
        res = '0;
        for (int k = 0; k < NM; k++) begin
            if (oh[k]) begin
                res = IW'(k);
            end
        end
        return res;
    endfunction

    // region match, lowest region wins so at most one slave is hit
    function automatic logic [NS-1:0] region_hit(input logic [AW-1:0] adr);
        logic [NS-1:0] res;
        res = '0;
        for (int k = NS - 1; k >= 0; k--) begin
            if ((adr & REGION_MASK[k]) == REGION_BASE[k]) begin
                res = '0;
                res[k] = 1'b1;
            end
        end
        return res;
    endfunction

    // one-hot slave vector to index for the read mux
    function automatic logic [SIW-1:0] s_index(input logic [NS-1:0] oh);
        logic [SIW-1:0] res;
        res = '0;
        for (int k = 0; k < NS; k++) begin
            if (oh[k]) begin
                res = SIW'(k);
            end
        end
        return res;
    endfunction

    logic [NM-1:0] pick;
    logic owned;
    logic [IW-1:0] own_idx;
    logic own_cyc;
    logic own_stb;
    logic [NS-1:0] hit;
    logic ack_or;
    logic rty_or;
    logic err_or;

    assign pick = rr_pick(m_cyc_i, st_q.last);
    assign owned = (st_q.state == ARB_OWNED);
    assign own_idx = st_q.last;

    // arbiter next state
    always_comb begin
        st_d = st_q;
        case (st_q.state)
            ARB_IDLE: begin
                if (|m_cyc_i) begin
                    st_d.state = ARB_OWNED;
                    st_d.grant = pick;
                    st_d.last = m_index(pick);
                end
            end
            ARB_OWNED: begin
                // hold while owned: nothing changes while the owner's cycle stays high
                if (!m_cyc_i[own_idx]) begin
                    // rotate to next requester, skipping levels with no request
                    if (|m_cyc_i) begin
                        st_d.grant = pick;
                        st_d.last = m_index(pick);
                    end else begin
                        // last kept so the rotation resumes after this owner
                        st_d.state = ARB_IDLE;
                        st_d.grant = '0;
                    end
                end
            end
            default: begin
                st_d = STATE_RST;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign grant_line_master_o = st_q.grant;
    assign grant_index_o = st_q.last;
    assign grant_valid_o = owned;

    // owner muxes; plain muxes, idle bus parks at zero rather than floating
    assign own_cyc = owned & m_cyc_i[own_idx];
    assign own_stb = own_cyc & m_stb_i[own_idx];
    assign s_cyc_o = own_cyc;
    assign s_we_o = owned & m_we_i[own_idx];
    assign s_adr_o = owned ? m_adr_i[own_idx] : '0;
    assign s_dat_o = owned ? m_dat_i[own_idx] : '0;
    assign s_sel_o = owned ? m_sel_i[own_idx] : '0;

    // address comparator; map set by REGION_BASE and REGION_MASK
    assign hit = region_hit(s_adr_o);
    // only the hit slave sees a strobe; an address in no region strobes none
    assign s_stb_o = own_stb ? hit : '0;

    assign ack_or = |s_ack_i;
    assign rty_or = |s_rty_i;
    assign err_or = |s_err_i;

    for (genvar g = 0; g < NM; g++) begin : g_term
        assign m_ack_o[g] = st_q.grant[g] & own_cyc & ack_or;
        assign m_rty_o[g] = st_q.grant[g] & own_cyc & rty_or;
        assign m_err_o[g] = st_q.grant[g] & own_cyc & err_or;
    end

    // read mux selected from decoded address; combinational to keep zero-wait reads
    assign m_dat_o = s_dat_i[s_index(hit)];

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // arbiter checks, then shared-bus routing, strobe, termination gating, ack and read-mux checks
    a_grant_onehot: assert property ($onehot0(grant_line_master_o))
        else $error("more than one grant line high");

    a_grant_after_req: assert property (!owned && (|m_cyc_i) |=> owned
        && ((grant_line_master_o & $past(m_cyc_i)) == grant_line_master_o))
        else $error("request not granted on next edge");

    a_index_match: assert property (owned |-> grant_line_master_o[grant_index_o]
        && $onehot(grant_line_master_o))
        else $error("grant index disagrees with grant lines");

    a_grant_hold: assert property (own_cyc |=> $stable(grant_line_master_o))
        else $error("grant moved while owner busy");

    a_idle_nogrant: assert property (!(|m_cyc_i) |=> grant_line_master_o == '0)
        else $error("grant issued with no request");

    a_rr_rotate: assert property (owned && !m_cyc_i[own_idx]
        && ((m_cyc_i & ~grant_line_master_o) != '0)
        |=> owned && grant_line_master_o != $past(grant_line_master_o))
        else $error("released owner not rotated away");

    a_release_idle: assert property (owned && !(|m_cyc_i) |=> !owned
        && grant_line_master_o == '0 && !s_cyc_o)
        else $error("bus not released after cycle low");

    a_addr_route: assert property (owned |-> s_adr_o == m_adr_i[grant_index_o]
        && s_dat_o == m_dat_i[grant_index_o])
        else $error("shared bus not driven by owner");

    a_stb_single: assert property ($onehot0(s_stb_o)
        && (!(|s_stb_o) || (own_stb && (region_hit(s_adr_o) == s_stb_o))))
        else $error("slave strobe wrong");

    a_term_gate: assert property (((m_ack_o | m_rty_o | m_err_o)
        & ~grant_line_master_o) == '0)
        else $error("termination reached non-owner");

    a_ack_or: assert property (own_cyc && (|s_ack_i) |-> m_ack_o[grant_index_o])
        else $error("owner missed ORed ack");

    a_read_mux: assert property ((|s_stb_o) |-> m_dat_o == s_dat_i[s_index(s_stb_o)])
        else $error("read data not from strobed slave");

    // termination checks for retry and error, and the quiet paths
    a_rty_or: assert property (own_cyc && (|s_rty_i) |-> m_rty_o[grant_index_o])
        else $error("owner missed ORed retry");

    a_err_or: assert property (own_cyc && (|s_err_i) |-> m_err_o[grant_index_o])
        else $error("owner missed ORed error");

    a_ack_exact: assert property ((|m_ack_o) == (own_cyc && (|s_ack_i)))
        else $error("ack seen without a slave ack");

    a_term_quiet: assert property (!own_cyc |-> (m_ack_o | m_rty_o | m_err_o) == '0)
        else $error("termination passed with no owner cycle");

    // shared control and idle parking
    a_ctl_route: assert property (owned |-> s_sel_o == m_sel_i[grant_index_o]
        && s_we_o == m_we_i[grant_index_o] && s_cyc_o == m_cyc_i[grant_index_o])
        else $error("shared control not driven by owner");

    a_idle_park: assert property (!owned |-> s_adr_o == '0 && s_dat_o == '0
        && s_sel_o == '0 && !s_we_o && !s_cyc_o && s_stb_o == '0)
        else $error("shared bus not parked while idle");

    // strobe and map checks
    a_stb_follow: assert property (own_stb |-> s_stb_o == region_hit(s_adr_o))
        else $error("owner strobe not passed to hit slave");

    a_no_stb_gap: assert property (!own_stb |-> s_stb_o == '0)
        else $error("slave strobed without owner strobe");

    a_ref_map: assert property (REGION_BASE == REGION_BASE_DEF
        && REGION_MASK == REGION_MASK_DEF && (|s_stb_o)
        |-> s_stb_o[s_adr_o[REGION_MSB:REGION_LSB]])
        else $error("reference map strobes wrong slave");

    // grant bookkeeping
    a_valid_match: assert property (grant_valid_o == (grant_line_master_o != '0))
        else $error("grant valid disagrees with grant lines");

    a_index_hold: assert property (own_cyc |=> grant_index_o == $past(grant_index_o))
        else $error("owner index moved while owner busy");

    // main scenarios
    c_block_burst: cover property (own_stb && ack_or ##1 own_cyc ##1 own_stb && ack_or);
    c_handover: cover property (owned && !m_cyc_i[own_idx] && (|m_cyc_i) ##1 owned);
    c_two_waiting: cover property (owned && ($countones(m_cyc_i) >= 3));
    c_error_term: cover property (own_cyc && err_or);
    c_retry_term: cover property (own_cyc && rty_or);

endmodule // shared_bus_mux_intercon

// ===== inc/shared_bus_mux_pkg.sv
// constants for the multiplexed shared-bus interconnect: port counts, widths, address map
// assumes every master and slave runs on the interconnect clock and uses separate in/out paths
package shared_bus_mux_pkg;

    // reference configuration
    localparam int NUM_MASTERS = 4;
    localparam int NUM_SLAVES = 4;
    localparam int ADR_WIDTH = 16;
    localparam int DAT_WIDTH = 32;
    localparam int SEL_WIDTH = 4;

    // reference map: bits 15..14 pick one of four 16 KB regions
    localparam int REGION_MSB = 15;
    localparam int REGION_LSB = 14;
    localparam logic [ADR_WIDTH-1:0] REGION_MASK_REF = 16'hC000;
    localparam logic [NUM_SLAVES-1:0][ADR_WIDTH-1:0] REGION_BASE_DEF =
        {16'hC000, 16'h8000, 16'h4000, 16'h0000};
    localparam logic [NUM_SLAVES-1:0][ADR_WIDTH-1:0] REGION_MASK_DEF =
        {REGION_MASK_REF, REGION_MASK_REF, REGION_MASK_REF, REGION_MASK_REF};

    // arbiter states
    typedef enum logic {
        ARB_IDLE,
        ARB_OWNED
    } arb_state_t;

endpackage

// ===== test/shared_bus_mux_intercon_test.sv
// bench for the shared-bus interconnect: single cycles to every region, then rotating owners
// assumes the slave model answers combinationally in the strobed cycle
module shared_bus_mux_intercon_test
    import shared_bus_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] m_cyc = '0, m_stb = '0, m_we = '0;
    logic [3:0][15:0] m_adr = '0;
    logic [3:0][31:0] m_dat = '0;
    logic [3:0][3:0] m_sel = '0;
    logic [1:0] mode = '0;
    logic [3:0] m_ack, m_rty, m_err, grant, s_stb, s_ack, s_rty, s_err, s_sel;
    logic [31:0] m_rdat, s_wdat;
    logic [3:0][31:0] s_rdat;
    logic [15:0] s_adr;
    logic [1:0] g_idx;
    logic g_valid, s_we, s_cyc;
    int n_mismatch = 0, n_compared = 0, n_cycles = 0;

    shared_bus_mux_intercon i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .m_cyc_i(m_cyc),
        .m_stb_i(m_stb), .m_we_i(m_we), .m_adr_i(m_adr), .m_dat_i(m_dat), .m_sel_i(m_sel),
        .m_ack_o(m_ack), .m_rty_o(m_rty), .m_err_o(m_err), .m_dat_o(m_rdat),
        .grant_line_master_o(grant), .grant_index_o(g_idx), .grant_valid_o(g_valid),
        .s_adr_o(s_adr), .s_dat_o(s_wdat), .s_sel_o(s_sel), .s_we_o(s_we), .s_cyc_o(s_cyc),
        .s_stb_o(s_stb), .s_ack_i(s_ack), .s_rty_i(s_rty), .s_err_i(s_err), .s_dat_i(s_rdat));
    slave_model i_slaves (.stb_i(s_stb), .mode_i(mode), .ack_o(s_ack), .rty_o(s_rty),
        .err_o(s_err), .dat_o(s_rdat));

    // 10 MHz clock; reset is driven from the initial block below
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // odd regions use their top address, even ones their base
    function automatic logic [15:0] addr(input int r);
        return {2'(r), (r % 2 == 1) ? 14'h3FFF : 14'h0000};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // caller has just passed a clock edge; all qualifiers go up together
    task automatic raise(input int m, input int r);
        m_cyc[m] <= 1'b1;
        m_stb[m] <= 1'b1;
        m_we[m] <= r[0];
        m_adr[m] <= addr(r);
        m_dat[m] <= 32'hC0DE0000 + 32'(m);
        m_sel[m] <= 4'(r + 1);
    endtask

    // two phases as owner, strobe dropped between them, then release the bus
    task automatic own(input int m, input int r);
        @(posedge ref_clk_i);
        for (int p = 0; p < 2; p++) begin
            #1;
            chk("grant", 32'(grant), 32'(1 << m));
            chk("index", {29'h0, g_valid, g_idx}, 32'(4 + m));
            chk("adr", 32'(s_adr), 32'(addr(r)));
            chk("wdat", s_wdat, 32'hC0DE0000 + 32'(m));
            chk("ctl", {26'h0, s_cyc, s_we, s_sel}, {26'h0, 1'b1, 1'(r % 2), 4'(r + 1)});
            chk("strobe", 32'(s_stb), 32'(1 << r));
            chk("term", 32'({m_err, m_rty, m_ack}), 32'(1 << (m + 4 * mode)));
            chk("rdat", m_rdat, 32'hA5A50000 + 32'(r));
            @(posedge ref_clk_i);
            // strobe down at the edge that took the termination
            m_stb[m] <= 1'b0;
            #1;
            chk("gap_own", {27'h0, s_cyc, grant}, 32'(16 + (1 << m)));
            chk("gap_term", {16'h0, s_stb, m_err, m_rty, m_ack}, 32'h0);
            @(posedge ref_clk_i);
            // next phase with cycle still high; cycle drops after the last
            if (p == 0) begin
                m_stb[m] <= 1'b1;
            end else begin
                m_cyc[m] <= 1'b0;
            end
        end
    endtask

    // one master per region, cycling through ack, retry and error
    task automatic scen_single();
        for (int r = 0; r < 4; r++) begin
            @(posedge ref_clk_i);
            mode <= 2'(r % 3);
            raise(r, r);
            own(r, r);
            @(posedge ref_clk_i);
            #1;
            chk("idle", {27'h0, g_valid, s_stb}, 32'h0);
        end
    endtask

    // three requesters at once after master 3 owned last: master 1 is skipped
    task automatic scen_rr();
        int order[3] = '{0, 2, 3};
        @(posedge ref_clk_i);
        mode <= 2'h0;
        foreach (order[k]) raise(order[k], (order[k] + 1) % 4);
        foreach (order[k]) own(order[k], (order[k] + 1) % 4);
    endtask

    // reset lands while master 1 owns the bus; grant is lost, then won again
    task automatic scen_reset();
        @(posedge ref_clk_i);
        raise(1, 2);
        @(posedge ref_clk_i);
        #1;
        chk("pre_rst", {27'h0, g_valid, grant}, 32'h12);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        #1;
        chk("mid_rst", {25'h0, g_valid, g_idx, s_stb}, 32'h0);
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        own(1, 2);
        @(posedge ref_clk_i);
        #1;
        chk("idle", {27'h0, g_valid, s_stb}, 32'h0);
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under 100 cycles
    always @(posedge ref_clk_i) begin
        n_cycles++;
        if (n_cycles == 500) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("reset", {27'h0, g_valid, s_stb}, 32'h0);
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        scen_single();
        scen_rr();
        scen_reset();
        end_of_test();
    end
endmodule // shared_bus_mux_intercon_test

// ===== test/slave_model.sv
// slave-side model: four memory-like slaves that answer in the cycle they are strobed
// assumes one-hot strobes from the interconnect; mode_i picks the kind of termination
module slave_model
    import shared_bus_mux_pkg::*;
(
    input wire logic [NUM_SLAVES-1:0] stb_i, // per-slave strobe
    input wire logic [1:0] mode_i, // 0 ack, 1 retry, 2 error
    output logic [NUM_SLAVES-1:0] ack_o, // acknowledges
    output logic [NUM_SLAVES-1:0] rty_o, // retries
    output logic [NUM_SLAVES-1:0] err_o, // errors
    output logic [NUM_SLAVES-1:0][DAT_WIDTH-1:0] dat_o // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    // silent unless strobed, then one termination for modes 0 to 2 and none for mode 3
    always_comb begin
        for (int i = 0; i < NUM_SLAVES; i++) begin
            ack_o[i] = stb_i[i] && (mode_i == 2'h0);
            rty_o[i] = stb_i[i] && (mode_i == 2'h1);
            err_o[i] = stb_i[i] && (mode_i == 2'h2);
            // unselected slaves show inverted data so a stale value never matches
            dat_o[i] = stb_i[i] ? 32'hA5A50000 + 32'(i) : ~(32'hA5A50000 + 32'(i));
        end
    end
endmodule // slave_model
